// ---- common/dsd_pkg.sv ----
// Package for the data space decoder with program window.
// Assumes one core clock; the core and the Wishbone master sit in that clock domain.
package dsd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned EA_W       = 16;
    localparam int unsigned PROG_W     = 24;
    localparam int unsigned PROG_DW    = 24;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned PAGE_W     = 8;
    localparam int unsigned WIN_LOW_W  = 15;
    localparam int unsigned WIN_SEL_B  = 15;

    // Register byte offsets on the Wishbone slave.
    localparam logic [3:0] OFS_CORE_CONTROL  = 4'h0;
    localparam logic [3:0] OFS_WINDOW_PAGE   = 4'h4;
    localparam logic [3:0] OFS_WINDOW_STATUS = 4'h8;

    // Field positions and reset values.
    localparam int unsigned CC_WIN_EN_B     = 2;
    localparam int unsigned ST_ACTIVE_B     = 24;
    localparam logic        RST_WIN_EN      = 1'b0;
    localparam logic [7:0]  RST_WINDOW_PAGE = 8'h00;

    // Extra instruction cycles added by a windowed read.
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_ONE  = 2'h1;
    localparam logic [1:0] EXTRA_TWO  = 2'h2;

    // Implemented data memory map; the X/Y boundary is fixed in hardware.
    localparam logic [15:0] Y_BASE   = 16'h0C00;
    localparam logic [15:0] Y_LAST   = 16'h0FFF;
    localparam logic [15:0] MEM_LAST = 16'h0FFF;

    typedef enum logic [1:0] {
        SRC_ZERO = 2'b00,
        SRC_XMEM = 2'b01,
        SRC_PROG = 2'b10
    } dsd_src_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        dual;
        logic        table_op;
        logic        short_cls;
        logic        in_repeat;
        logic        rpt_first;
        logic        rpt_last;
        logic        rpt_irq_exit;
        logic        rpt_irq_resume;
        logic        bitrev;
        logic [15:0] x_ea;
        logic [15:0] y_ea;
        logic [15:0] wdata;
    } dsd_req_s;

    typedef struct packed {
        logic        wb_cyc;
        logic        wb_stb;
        logic        wb_we;
        logic [3:0]  wb_adr;
        logic [3:0]  wb_sel;
        logic [31:0] wb_dat;
    } dsd_wb_req_s;

endpackage

// ---- design/dsd_top.sv ----
// Data space decoder: routes core effective addresses to X memory, Y memory or the program window.
// Assumes the core, the memories and the Wishbone master all run on i_sys_clk; memory read data
// stands in the same cycle as the registered read strobe, so the memories must answer without a clock.
`timescale 1ns/100ps
`default_nettype none

module dsd_top #(
    parameter logic [15:0] P_Y_BASE   = dsd_pkg::Y_BASE,
    parameter logic [15:0] P_Y_LAST   = dsd_pkg::Y_LAST,
    parameter logic [15:0] P_MEM_LAST = dsd_pkg::MEM_LAST
) (
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst,
    input  wire dsd_pkg::dsd_req_s  i_req,
    input  wire logic [15:0]        i_xmem_rdata,
    input  wire logic [15:0]        i_ymem_rdata,
    input  wire logic [23:0]        i_prog_rdata,
    input  wire dsd_pkg::dsd_wb_req_s i_wb,
    output logic [15:0]             o_xmem_addr,
    output logic                    o_xmem_rd,
    output logic                    o_xmem_we,
    output logic [15:0]             o_xmem_wdata,
    output logic                    o_bitrev_en,
    output logic [15:0]             o_ymem_addr,
    output logic                    o_ymem_rd,
    output logic [23:0]             o_prog_addr,
    output logic                    o_prog_rd,
    output logic [1:0]              o_extra_cycles,
    output logic                    o_rd_valid,
    output logic [15:0]             o_x_rdata,
    output logic [15:0]             o_y_rdata,
    output logic                    o_wb_ack,
    output logic [31:0]             o_wb_dat
);

    ////////////////////////////////////////////////////////////////////////////////
    logic                   win_en_q;
    logic [7:0]             page_q;
    logic [23:0]            last_prog_q;
    logic                   last_active_q;
    dsd_pkg::dsd_src_e      xsrc_q;
    logic                   ysel_q;
    logic                   rd_pend_q;
    logic                   win_hit;
    logic                   x_in_y;
    logic                   y_in_y;
    logic                   x_impl;
    logic                   rd_req;
    logic                   wb_go;
    logic [1:0]             extra_d;
    dsd_pkg::dsd_src_e      xsrc_d;

    // The window is blind during table instructions so table reads see raw program space.
    assign win_hit = i_req.x_ea[dsd_pkg::WIN_SEL_B] & win_en_q & ~i_req.table_op;
    assign x_in_y  = (i_req.x_ea >= P_Y_BASE) && (i_req.x_ea <= P_Y_LAST);
    assign y_in_y  = (i_req.y_ea >= P_Y_BASE) && (i_req.y_ea <= P_Y_LAST);
    assign x_impl  = (i_req.x_ea <= P_MEM_LAST);
    assign rd_req  = i_req.valid & ~i_req.write;
    assign wb_go   = i_wb.wb_cyc & i_wb.wb_stb & ~o_wb_ack;

    ////////////////////////////////////////////////////////////////////////////////
    // X read source selection.
    always_comb begin
        if (win_hit) begin
            xsrc_d = dsd_pkg::SRC_PROG;
        end else if (i_req.dual && x_in_y) begin
            xsrc_d = dsd_pkg::SRC_ZERO;
        end else if (x_impl) begin
            xsrc_d = dsd_pkg::SRC_XMEM;
        end else begin
            xsrc_d = dsd_pkg::SRC_ZERO;
        end
    end

    // Extra cycles for a windowed read.
    always_comb begin
        extra_d = dsd_pkg::EXTRA_NONE;
        if (rd_req && win_hit) begin
            if (!i_req.in_repeat) begin
                extra_d = i_req.short_cls ? dsd_pkg::EXTRA_ONE : dsd_pkg::EXTRA_TWO;
            end else if (i_req.rpt_first | i_req.rpt_last | i_req.rpt_irq_exit | i_req.rpt_irq_resume) begin
                extra_d = dsd_pkg::EXTRA_TWO;
            end else begin
                extra_d = dsd_pkg::EXTRA_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address stage: strobes and addresses for one cycle per request.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_xmem_addr    <= 16'h0000;
            o_xmem_rd      <= 1'b0;
            o_ymem_addr    <= 16'h0000;
            o_ymem_rd      <= 1'b0;
            o_prog_addr    <= 24'h000000;
            o_prog_rd      <= 1'b0;
            o_extra_cycles <= 2'h0;
            xsrc_q         <= dsd_pkg::SRC_ZERO;
            ysel_q         <= 1'b0;
            rd_pend_q      <= 1'b0;
        end else begin
            o_xmem_addr    <= i_req.x_ea;
            o_xmem_rd      <= rd_req && (xsrc_d == dsd_pkg::SRC_XMEM);
            o_ymem_addr    <= i_req.y_ea;
            o_ymem_rd      <= rd_req && i_req.dual && y_in_y;
            o_prog_addr    <= {1'b0, page_q, i_req.x_ea[dsd_pkg::WIN_LOW_W-1:0]};
            o_prog_rd      <= rd_req && win_hit;
            o_extra_cycles <= extra_d;
            xsrc_q         <= xsrc_d;
            ysel_q         <= i_req.dual && y_in_y;
            rd_pend_q      <= rd_req;
        end
    end

    // Write path: only the X write bus exists, so accumulator write-back lands here too.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_xmem_we    <= 1'b0;
            o_xmem_wdata <= 16'h0000;
            o_bitrev_en  <= 1'b0;
        end else begin
            o_xmem_we    <= i_req.valid & i_req.write & x_impl;
            o_xmem_wdata <= i_req.wdata;
            o_bitrev_en  <= i_req.valid & i_req.write & x_impl & i_req.bitrev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data stage: memory answers are steered and invalid reads forced to zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_valid <= 1'b0;
            o_x_rdata  <= 16'h0000;
            o_y_rdata  <= 16'h0000;
        end else begin
            o_rd_valid <= rd_pend_q;
            unique case (xsrc_q)
                dsd_pkg::SRC_XMEM: o_x_rdata <= i_xmem_rdata;
                dsd_pkg::SRC_PROG: o_x_rdata <= i_prog_rdata[dsd_pkg::DATA_W-1:0];
                default:           o_x_rdata <= 16'h0000;
            endcase
            o_y_rdata <= ysel_q ? i_ymem_rdata : 16'h0000;
        end
    end

    // Last windowed program address, kept for software visibility.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            last_prog_q   <= 24'h000000;
            last_active_q <= 1'b0;
        end else if (o_prog_rd) begin
            last_prog_q   <= o_prog_addr;
            last_active_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle ack, released the cycle after; unmapped reads give zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= wb_go;
            o_wb_dat <= 32'h00000000;
            if (wb_go && !i_wb.wb_we) begin
                unique case (i_wb.wb_adr)
                    dsd_pkg::OFS_CORE_CONTROL:  o_wb_dat[dsd_pkg::CC_WIN_EN_B] <= win_en_q;
                    dsd_pkg::OFS_WINDOW_PAGE:   o_wb_dat[7:0] <= page_q;
                    dsd_pkg::OFS_WINDOW_STATUS: o_wb_dat <= {7'h00, last_active_q, last_prog_q};
                    default:                    o_wb_dat <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            win_en_q <= dsd_pkg::RST_WIN_EN;
            page_q   <= dsd_pkg::RST_WINDOW_PAGE;
        end else if (wb_go && i_wb.wb_we && i_wb.wb_sel[0]) begin
            if (i_wb.wb_adr == dsd_pkg::OFS_CORE_CONTROL) begin
                win_en_q <= i_wb.wb_dat[dsd_pkg::CC_WIN_EN_B];
            end
            if (i_wb.wb_adr == dsd_pkg::OFS_WINDOW_PAGE) begin
                page_q <= i_wb.wb_dat[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_win_read;
        rd_req && i_req.x_ea[15] && win_en_q && !i_req.table_op;
    endsequence

    sequence s_win_plain;
        s_win_read ##0 !i_req.in_repeat;
    endsequence

    property p_win_addr;
        s_win_read |=> o_prog_rd && o_prog_addr == {1'b0, $past(page_q), $past(i_req.x_ea[14:0])};
    endproperty
    a_win_addr: assert property (p_win_addr) else $error("Window address wrong.");

    property p_no_win;
        (rd_req && (!i_req.x_ea[15] || !win_en_q || i_req.table_op)) |=> !o_prog_rd;
    endproperty
    a_no_win: assert property (p_no_win) else $error("Program read outside window.");

    property p_win_data;
        s_win_read ##1 1'b1 |=> o_rd_valid && o_x_rdata == $past(i_prog_rdata[15:0]);
    endproperty
    a_win_data: assert property (p_win_data) else $error("Window data not low half.");

    property p_extra_one;
        s_win_plain ##0 i_req.short_cls |=> o_extra_cycles == 2'h1;
    endproperty
    a_extra_one: assert property (p_extra_one) else $error("Short class extra wrong.");

    property p_extra_two;
        s_win_plain ##0 !i_req.short_cls |=> o_extra_cycles == 2'h2;
    endproperty
    a_extra_two: assert property (p_extra_two) else $error("Other class extra wrong.");

    property p_rpt_edge;
        s_win_read ##0 (i_req.in_repeat && (i_req.rpt_first || i_req.rpt_last
                        || i_req.rpt_irq_exit || i_req.rpt_irq_resume)) |=> o_extra_cycles == 2'h2;
    endproperty
    a_rpt_edge: assert property (p_rpt_edge) else $error("Repeat edge extra wrong.");

    property p_rpt_mid;
        s_win_read ##0 (i_req.in_repeat && !i_req.rpt_first && !i_req.rpt_last
                        && !i_req.rpt_irq_exit && !i_req.rpt_irq_resume) |=> o_extra_cycles == 2'h0;
    endproperty
    a_rpt_mid: assert property (p_rpt_mid) else $error("Repeat middle not single cycle.");

    property p_zero_x;
        (rd_req && i_req.dual && x_in_y && !win_hit) |=> ##1 o_x_rdata == 16'h0000;
    endproperty
    a_zero_x: assert property (p_zero_x) else $error("X pointer into Y not zero.");

    property p_zero_y;
        (rd_req && i_req.dual && !y_in_y) |=> !o_ymem_rd ##1 o_y_rdata == 16'h0000;
    endproperty
    a_zero_y: assert property (p_zero_y) else $error("Y pointer into X not zero.");

    property p_write;
        (i_req.valid && i_req.write && x_impl) |=> o_xmem_we && o_xmem_wdata == $past(i_req.wdata) && !o_ymem_rd;
    endproperty
    a_write: assert property (p_write) else $error("Write not on X bus.");

    property p_bitrev;
        o_bitrev_en |-> o_xmem_we && $past(i_req.write) && $past(i_req.bitrev);
    endproperty
    a_bitrev: assert property (p_bitrev) else $error("Bit reverse outside X write.");

    property p_ack;
        wb_go |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("Bus ack not one cycle.");

endmodule // dsd_top

`default_nettype wire

// ---- test/dsd_mem_model.sv ----
// Behavioural X, Y and program memories that answer the decoder's read strobes.
// Assumes the strobes come from flip-flops; data stands in the strobe's own cycle.
`timescale 1ns/100ps
`default_nettype none

module dsd_mem_model (
    input  wire logic [15:0] i_xmem_addr,
    input  wire logic        i_xmem_rd,
    input  wire logic [15:0] i_ymem_addr,
    input  wire logic        i_ymem_rd,
    input  wire logic [23:0] i_prog_addr,
    input  wire logic        i_prog_rd,
    output logic      [15:0] o_xmem_rdata,
    output logic      [15:0] o_ymem_rdata,
    output logic      [23:0] o_prog_rdata
);
    ////////////////////////////////////////////////////////////////////////////////
    // Without a strobe the data is inverted, so a sample taken in the wrong cycle never matches.
    assign o_xmem_rdata = i_xmem_rd ? (i_xmem_addr ^ 16'h5A5A) : ~(i_xmem_addr ^ 16'h5A5A);
    assign o_ymem_rdata = i_ymem_rd ? (i_ymem_addr ^ 16'hA5A5) : ~(i_ymem_addr ^ 16'hA5A5);
    // Upper byte of every strobed constant word holds an illegal opcode pattern; without a strobe it is zero.
    assign o_prog_rdata = i_prog_rd ? {8'hFF, i_prog_addr[15:0] ^ i_prog_addr[23:8]}
                                    : {8'h00, ~(i_prog_addr[15:0] ^ i_prog_addr[23:8])};
endmodule // dsd_mem_model
`default_nettype wire

// ---- test/dsd_top_tb.sv ----
// Self-checking bench for the data space decoder, with random core accesses and register traffic.
// Assumes dsd_mem_model answers the memory strobes; the bench acts as core and Wishbone master.
`timescale 1ns/100ps
`default_nettype none

module dsd_top_tb;
    logic                  i_sys_clk = 1'b0;
    logic                  i_rst     = 1'b1;
    dsd_pkg::dsd_req_s     i_req     = '0;
    dsd_pkg::dsd_wb_req_s  i_wb      = '0;
    logic [15:0]           xrd, yrd, xa, wd, ya, s, xe, yd;
    logic [23:0]           prd, pa, last_pa;
    logic [31:0]           wdat, rd;
    logic [1:0]            ex;
    logic                  xr, xw, br, yr, pr, rv, en, ack;
    logic [7:0]            page;
    int                    error_cnt = 0;
    int                    n_compared = 0;

    always #10 i_sys_clk = ~i_sys_clk;

    dsd_top DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(i_req), .i_xmem_rdata(xrd),
        .i_ymem_rdata(yrd), .i_prog_rdata(prd), .i_wb(i_wb), .o_xmem_addr(xa), .o_xmem_rd(xr),
        .o_xmem_we(xw), .o_xmem_wdata(wd), .o_bitrev_en(br), .o_ymem_addr(ya), .o_ymem_rd(yr),
        .o_prog_addr(pa), .o_prog_rd(pr), .o_extra_cycles(ex), .o_rd_valid(rv), .o_x_rdata(xe),
        .o_y_rdata(yd), .o_wb_ack(ack), .o_wb_dat(wdat));
    dsd_mem_model MEM (.i_xmem_addr(xa), .i_xmem_rd(xr), .i_ymem_addr(ya),
        .i_ymem_rd(yr), .i_prog_addr(pa), .i_prog_rd(pr), .o_xmem_rdata(xrd), .o_ymem_rdata(yrd),
        .o_prog_rdata(prd));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic iny(input logic [15:0] a);
        return a >= dsd_pkg::Y_BASE && a <= dsd_pkg::Y_LAST;
    endfunction
    function automatic logic [15:0] exp_x(input dsd_pkg::dsd_req_s r, input logic w, input logic [23:0] p);
        if (w) return p[15:0] ^ p[23:8];
        if (r.x_ea > dsd_pkg::MEM_LAST || (r.dual && iny(r.x_ea))) return 16'h0000;
        return r.x_ea ^ 16'h5A5A;
    endfunction
    function automatic logic [1:0] exp_ex(input dsd_pkg::dsd_req_s r, input logic w);
        if (!w) return dsd_pkg::EXTRA_NONE;
        if (r.in_repeat)
            return (r.rpt_first | r.rpt_last | r.rpt_irq_exit | r.rpt_irq_resume) ? dsd_pkg::EXTRA_TWO
                                                                                 : dsd_pkg::EXTRA_NONE;
        return r.short_cls ? dsd_pkg::EXTRA_ONE : dsd_pkg::EXTRA_TWO;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Classic single Wishbone cycle; the request stands until ack is sampled high.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge i_sys_clk);
        i_wb <= '{wb_cyc: 1'b1, wb_stb: 1'b1, wb_we: we, wb_adr: adr, wb_sel: 4'hF, wb_dat: d};
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (ack !== 1'b1);
        q = wdat;
        chk("wb_ack_cycles", 2, k);
        i_wb <= '0;
        @(posedge i_sys_clk);
    endtask

    task automatic core(input dsd_pkg::dsd_req_s r);
        logic w;
        logic [23:0] p;
        int k;
        w = r.x_ea[15] & en & !r.table_op & !r.write;
        p = {1'b0, page, r.x_ea[14:0]};
        @(posedge i_sys_clk);
        i_req <= r;
        @(posedge i_sys_clk);
        i_req.valid <= 1'b0;
        @(negedge i_sys_clk);
        chk("prog_rd", w, pr);
        chk("extra", exp_ex(r, w), ex);
        chk("ymem_rd", r.dual & iny(r.y_ea) & !r.write, yr);
        chk("xmem_we", r.write & (r.x_ea <= dsd_pkg::MEM_LAST), xw);
        if (w) chk("prog_addr", p, pa);
        if (w) last_pa = p;
        chk("bitrev", r.bitrev & r.write & (r.x_ea <= dsd_pkg::MEM_LAST), br);
        if (xw === 1'b1) chk("write", {r.x_ea, r.wdata}, {xa, wd});
        if (yr === 1'b1) chk("ymem_addr", r.y_ea, ya);
        if (r.write) return;
        k = 0;
        while (rv !== 1'b1 && k < 4) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk("rd_valid", 1, rv);
        chk("x_rdata", exp_x(r, w, p), xe);
        chk("y_rdata", (r.dual & iny(r.y_ea)) ? r.y_ea ^ 16'hA5A5 : 16'h0000, yd);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        dsd_pkg::dsd_req_s r;
        s = 16'h0023;
        en = 1'b0;
        page = 8'h00;
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        wb(1'b0, dsd_pkg::OFS_CORE_CONTROL, 0, rd); chk("cc_reset", 0, rd);
        wb(1'b0, dsd_pkg::OFS_WINDOW_PAGE, 0, rd); chk("page_reset", 0, rd);
        wb(1'b0, dsd_pkg::OFS_WINDOW_STATUS, 0, rd); chk("status_reset", 0, rd);
        wb(1'b1, 4'hC, 32'hFFFFFFFF, rd); wb(1'b0, 4'hC, 0, rd); chk("unmapped", 0, rd);
        for (int ph = 0; ph < 3; ph++) begin
            en = ph != 1;
            s = lfsr(s);
            page = (ph == 2) ? 8'hFF : s[7:0];
            wb(1'b1, dsd_pkg::OFS_CORE_CONTROL, en ? 32'hFFFFFFFF : 32'h0, rd);
            wb(1'b0, dsd_pkg::OFS_CORE_CONTROL, 0, rd); chk("cc", {29'h0, en, 2'h0}, rd);
            wb(1'b1, dsd_pkg::OFS_WINDOW_PAGE, {24'h0, page}, rd);
            wb(1'b0, dsd_pkg::OFS_WINDOW_PAGE, 0, rd); chk("page", page, rd);
            for (int i = 0; i < 70; i++) begin
                s = lfsr(s); r = '0; r.valid = 1'b1; r.x_ea = s; r.wdata = ~s;
                s = lfsr(s);
                case (s[1:0])
                    2'd0: r.x_ea[15] = 1'b1;
                    2'd1: r.x_ea = {4'h0, r.x_ea[11:0]};
                    2'd3: r.x_ea = {6'h03, r.x_ea[9:0]};
                    default: ;
                endcase
                r.y_ea = s[2] ? {6'h03, s[15:6]} : {s[15:6], 6'h00};
                r.write = s[3] & s[4];
                r.dual = !r.write & s[5];
                r.table_op = s[6] & s[7];
                r.short_cls = s[8];
                r.in_repeat = s[9];
                r.rpt_first = s[10] & s[11];
                r.rpt_last = s[12] & s[13];
                r.rpt_irq_exit = s[14] & s[11];
                r.rpt_irq_resume = s[15] & s[13];
                r.bitrev = s[14];
                core(r);
            end
        end
        wb(1'b0, dsd_pkg::OFS_WINDOW_STATUS, 0, rd); chk("status", {7'h0, 1'b1, last_pa}, rd);
        // A second reset in mid-run must bring the registers and strobes back to idle.
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        chk("outs_rst", 0, {pr, xw, br, yr, rv, ack, ex});
        wb(1'b0, dsd_pkg::OFS_CORE_CONTROL, 0, rd); chk("cc_rerst", 0, rd);
        wb(1'b0, dsd_pkg::OFS_WINDOW_PAGE, 0, rd); chk("page_rerst", 0, rd);
        wb(1'b0, dsd_pkg::OFS_WINDOW_STATUS, 0, rd); chk("status_rerst", 0, rd);
        tally_and_finish();
    end
endmodule // dsd_top_tb
`default_nettype wire
